// ===== rtl/wsc_regs.svh
// register offsets, field positions, reset values and timing constants of the watchdog and sleep block
// assumes inclusion by bare name from the package and the design module
`ifndef WSC_REGS_SVH
`define WSC_REGS_SVH
// ----------------------------------------------------------------
// register map (byte addresses on apb)
// ----------------------------------------------------------------
`define WSC_OFF_WDT_CTRL 12'h000
`define WSC_OFF_PRESCALE_OPT 12'h004
`define WSC_OFF_STATUS 12'h008
`define WSC_OFF_IRQ_CTRL 12'h00C
`define WSC_OFF_CMD 12'h010
// ----------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------
`define WSC_WDT_CTRL_RST 8'h08
`define WSC_PRESCALE_OPT_RST 8'hFF
`define WSC_WDT_CTRL_MASK 8'h1F
`define WSC_BIT_SW_EN 0
`define WSC_PS_LSB 1
`define WSC_PS_MSB 4
`define WSC_PS_MAX 4'hB
`define WSC_PS_BASE 5
`define WSC_CMD_CLEAR_WATCHDOG_INSTR 0
`define WSC_CMD_SLEEP 1
`define WSC_CMD_OSCFAIL 2
`define WSC_STAT_EXPIRY_N 0
`define WSC_STAT_SLEEP_N 1
`define WSC_STAT_ASLEEP 2
`define WSC_STAT_OST 3
`define WSC_IRQ_SRC_W 6
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define WSC_CLK_HZ 100000000
`define WSC_LFOSC_HZ 31000
`define WSC_LFOSC_DIV (`WSC_CLK_HZ / `WSC_LFOSC_HZ)
`define WSC_OST_TICKS 1024
`endif

// ===== rtl/wsc_pkg.sv
// types shared by the watchdog and sleep control block
// assumes wsc_regs.svh sits next to it
`include "wsc_regs.svh"
package wsc_pkg;
    // ----------------------------------------------------------------
    // sleep controller states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        WSC_AWAKE = 2'b00,
        WSC_ASLEEP = 2'b01,
        WSC_OST_RUN = 2'b10
    } wsc_state_t;
    // reset and wake reporting to the core
    typedef struct packed {
        logic wdt_reset;
        logic wake_resume;
        logic wake_reset;
        logic vector_req;
    } wsc_evt_t;
    // pin and configuration straps
    typedef struct packed {
        logic config_watchdog_always_on;
        logic wakeup_reset_enable_n;
        logic crystal_clock;
    } wsc_cfg_t;
endpackage

// ===== rtl/wsc_watchdog_sleep.sv
// watchdog timer with 16-bit prescaler and sleep entry and wake-up control
// assumes apb master, synchronous straps and interrupt levels, one 100 MHz clock
// Functional notes
// - watchdog ticks from 31 kHz low-frequency oscillator
// - reset loads control 0x08, period 1:512
// - start-up timer holds watchdog in reset
// - 16-bit prescaler divides by 32 to 65536
// - always-on strap ignores software enable
// - otherwise software enable bit runs watchdog
// - period codes 0..11 double; 12..15 reserved
// - upper three control bits read zero
// - clear instruction clears the watchdog count
// - crystal wake keeps watchdog cleared through start-up
// - sleep clears watchdog and power-down flag, sets timeout flag, stops oscillator, holds pins
// - wake on master clear, watchdog, enabled interrupt
// - power-down flag set at power-up; timeout flag cleared on watchdog expiry
// - sleep wake only from clockless interrupt sources
// - own enable wakes; global enable selects vector
// - instruction after sleep is prefetched
// - interrupt and watchdog wakes clear the watchdog; master clear wake does not
// - pending interrupt makes sleep a no-operation
// - interrupt during sleep completes sleep then wakes
// - wake-up reset option forces full reset
// - watchdog reset never drives master clear pin
//
// Local design decisions: the APB interface to the registers and the address map.
`include "wsc_regs.svh"
module wsc_watchdog_sleep (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire wsc_pkg::wsc_cfg_t cfg,
    input wire logic master_clear_pin_n,
    input wire logic [`WSC_IRQ_SRC_W-1:0] irq_flag,
    input wire logic [`WSC_IRQ_SRC_W-1:0] irq_enable,
    input wire logic global_irq_enable,
    output wsc_pkg::wsc_evt_t evt,
    output logic osc_driver_on,
    output logic io_hold,
    output logic master_clear_drive_low
);
    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    logic [7:0] wdt_ctrl_ff;
    logic [7:0] prescale_opt_ff;
    logic expiry_flag_n_ff;
    logic sleep_entered_flag_n_ff;
    logic clear_watchdog_instr;
    logic sleep_instr;
    logic osc_fail;
    logic [31:0] nxt_prdata;
    logic addr_ok;
    logic wr_acc;
    logic [3:0] period_select;
    logic run_en;
    logic wdt_clear;
    logic ost_hold;
    logic lf_tick;
    logic wdt_expire;
    logic irq_pending;
    wsc_pkg::wsc_state_t state_ff;
    logic [9:0] ost_cnt_ff;

    assign pready = 1'b1;
    assign wr_acc = psel && penable && pwrite;
    // address decode; unmapped addresses answer with an error
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        addr_ok = 1'b1;
        if (paddr == `WSC_OFF_WDT_CTRL) begin
            nxt_prdata[7:0] = wdt_ctrl_ff & `WSC_WDT_CTRL_MASK;
        end else if (paddr == `WSC_OFF_PRESCALE_OPT) begin
            nxt_prdata[7:0] = prescale_opt_ff;
        end else if (paddr == `WSC_OFF_STATUS) begin
            nxt_prdata[`WSC_STAT_EXPIRY_N] = expiry_flag_n_ff;
            nxt_prdata[`WSC_STAT_SLEEP_N] = sleep_entered_flag_n_ff;
            nxt_prdata[`WSC_STAT_ASLEEP] = (state_ff != wsc_pkg::WSC_AWAKE);
            nxt_prdata[`WSC_STAT_OST] = (state_ff == wsc_pkg::WSC_OST_RUN);
        end else if (paddr == `WSC_OFF_IRQ_CTRL) begin
            nxt_prdata[`WSC_IRQ_SRC_W-1:0] = irq_enable & irq_flag;
        end else if (paddr == `WSC_OFF_CMD) begin
            nxt_prdata = 32'h0000_0000;
        end else begin
            addr_ok = 1'b0;
        end
    end
    assign prdata = nxt_prdata;
    assign pslverr = psel && penable && !addr_ok;

    // control registers; reserved bits are never stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_ctrl_ff <= `WSC_WDT_CTRL_RST;
            prescale_opt_ff <= `WSC_PRESCALE_OPT_RST;
        end else if (wr_acc && paddr == `WSC_OFF_WDT_CTRL) begin
            wdt_ctrl_ff <= pwdata[7:0] & `WSC_WDT_CTRL_MASK;
        end else if (wr_acc && paddr == `WSC_OFF_PRESCALE_OPT) begin
            prescale_opt_ff <= pwdata[7:0];
        end
    end

    // command strobes from the core: one-cycle pulses on a write to the command word
    assign clear_watchdog_instr = wr_acc && paddr == `WSC_OFF_CMD && pwdata[`WSC_CMD_CLEAR_WATCHDOG_INSTR];
    assign sleep_instr = wr_acc && paddr == `WSC_OFF_CMD && pwdata[`WSC_CMD_SLEEP];
    assign osc_fail = wr_acc && paddr == `WSC_OFF_CMD && pwdata[`WSC_CMD_OSCFAIL];

    // ----------------------------------------------------------------
    // low-frequency oscillator model and prescaler
    // ----------------------------------------------------------------
    logic [12:0] lf_div_ff;
    logic [15:0] presc_ff;
    logic [15:0] period_mask;
    assign period_select = wdt_ctrl_ff[`WSC_PS_MSB:`WSC_PS_LSB];
    // the oscillator keeps running in sleep, so the watchdog can wake the part
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lf_div_ff <= 13'h0000;
        end else if (lf_div_ff == 13'(`WSC_LFOSC_DIV - 1)) begin
            lf_div_ff <= 13'h0000;
        end else begin
            lf_div_ff <= lf_div_ff + 13'h0001;
        end
    end
    assign lf_tick = (lf_div_ff == 13'(`WSC_LFOSC_DIV - 1));

    assign run_en = cfg.config_watchdog_always_on || wdt_ctrl_ff[`WSC_BIT_SW_EN];
    assign irq_pending = |(irq_flag & irq_enable);
    assign ost_hold = (state_ff == wsc_pkg::WSC_OST_RUN);

    // reserved codes clamp to the longest period
    always_comb begin
        if (period_select > `WSC_PS_MAX) begin
            period_mask = 16'hFFFF;
        end else begin
            period_mask = 16'((32'h1 << (period_select + `WSC_PS_BASE)) - 32'h1);
        end
    end

    // sleep taken only when no enabled interrupt is already pending
    logic sleep_take;
    assign sleep_take = sleep_instr && (state_ff == wsc_pkg::WSC_AWAKE) && !irq_pending;
    logic wake_evt;

    assign wdt_clear = clear_watchdog_instr || sleep_take || wake_evt || osc_fail || ost_hold;
    assign wdt_expire = run_en && lf_tick && !ost_hold && ((presc_ff & period_mask) == period_mask);

    // watchdog counter: clears dominate counting
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_ff <= 16'h0000;
        end else if (wdt_clear || wdt_expire) begin
            presc_ff <= 16'h0000;
        end else if (run_en && lf_tick) begin
            presc_ff <= presc_ff + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // sleep state machine
    // ----------------------------------------------------------------
    logic wake_irq;
    logic wake_wdt;
    assign wake_irq = (state_ff == wsc_pkg::WSC_ASLEEP) && irq_pending;
    assign wake_wdt = (state_ff == wsc_pkg::WSC_ASLEEP) && wdt_expire;
    assign wake_evt = wake_irq || wake_wdt;

    // crystal clocks run the start-up timer before execution resumes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= wsc_pkg::WSC_AWAKE;
            ost_cnt_ff <= 10'h000;
        end else begin
            case (state_ff)
                wsc_pkg::WSC_AWAKE: begin
                    if (sleep_take) begin
                        state_ff <= wsc_pkg::WSC_ASLEEP;
                    end
                end
                wsc_pkg::WSC_ASLEEP: begin
                    if (!master_clear_pin_n) begin
                        state_ff <= wsc_pkg::WSC_AWAKE;
                    end else if (wake_evt && cfg.crystal_clock) begin
                        state_ff <= wsc_pkg::WSC_OST_RUN;
                        ost_cnt_ff <= 10'h000;
                    end else if (wake_evt) begin
                        state_ff <= wsc_pkg::WSC_AWAKE;
                    end
                end
                wsc_pkg::WSC_OST_RUN: begin
                    if (ost_cnt_ff == 10'(`WSC_OST_TICKS - 1)) begin
                        state_ff <= wsc_pkg::WSC_AWAKE;
                    end else begin
                        ost_cnt_ff <= ost_cnt_ff + 10'h001;
                    end
                end
                default: begin
                    state_ff <= wsc_pkg::WSC_AWAKE;
                end
            endcase
        end
    end

    // status flags; a timeout flag clear outranks the sleep set in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            expiry_flag_n_ff <= 1'b1;
            sleep_entered_flag_n_ff <= 1'b1;
        end else if (wdt_expire) begin
            expiry_flag_n_ff <= 1'b0;
        end else if (sleep_take) begin
            expiry_flag_n_ff <= 1'b1;
            sleep_entered_flag_n_ff <= 1'b0;
        end else if (clear_watchdog_instr) begin
            expiry_flag_n_ff <= 1'b1;
            sleep_entered_flag_n_ff <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // outputs to the core
    // ----------------------------------------------------------------
    logic resume_pend_ff;
    wsc_pkg::wsc_evt_t evt_ff;
    logic resume_now;
    // resume after start-up when the wake came from a crystal-clocked sleep
    assign resume_now = (wake_evt && !cfg.crystal_clock) ||
        (state_ff == wsc_pkg::WSC_OST_RUN && ost_cnt_ff == 10'(`WSC_OST_TICKS - 1));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_ff <= '0;
            resume_pend_ff <= 1'b0;
        end else begin
            evt_ff.wdt_reset <= wdt_expire && (state_ff == wsc_pkg::WSC_AWAKE);
            evt_ff.wake_reset <= resume_now && !cfg.wakeup_reset_enable_n;
            evt_ff.wake_resume <= resume_now && cfg.wakeup_reset_enable_n;
            evt_ff.vector_req <= resume_now && cfg.wakeup_reset_enable_n && global_irq_enable
                && (wake_irq || resume_pend_ff);
            if (wake_evt) begin
                resume_pend_ff <= wake_irq;
            end else if (resume_now) begin
                resume_pend_ff <= 1'b0;
            end
        end
    end
    assign evt = evt_ff;
    assign osc_driver_on = (state_ff != wsc_pkg::WSC_ASLEEP);
    assign io_hold = (state_ff == wsc_pkg::WSC_ASLEEP);
    assign master_clear_drive_low = 1'b0;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_ctrl_upper_zero;
        @(posedge clk) disable iff (!rst_n) wdt_ctrl_ff[7:5] == 3'b000;
    endproperty
    a_ctrl_upper_zero: assert property (p_ctrl_upper_zero) else $error("control upper bits set");
    property p_clear_on_cmd;
        @(posedge clk) disable iff (!rst_n) clear_watchdog_instr |=> presc_ff == 16'h0000;
    endproperty
    a_clear_on_cmd: assert property (p_clear_on_cmd) else $error("count not cleared");
    property p_sleep_entry;
        @(posedge clk) disable iff (!rst_n) sleep_take && !wdt_expire |=>
            !sleep_entered_flag_n_ff && expiry_flag_n_ff && io_hold && !osc_driver_on;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");
    property p_pending_nop;
        @(posedge clk) disable iff (!rst_n)
            sleep_instr && irq_pending && state_ff == wsc_pkg::WSC_AWAKE |=> state_ff == wsc_pkg::WSC_AWAKE;
    endproperty
    a_pending_nop: assert property (p_pending_nop) else $error("sleep not skipped");
    property p_ost_hold;
        @(posedge clk) disable iff (!rst_n) state_ff == wsc_pkg::WSC_OST_RUN |=> presc_ff == 16'h0000;
    endproperty
    a_ost_hold: assert property (p_ost_hold) else $error("watchdog ran during start-up");
    property p_wake_clears;
        @(posedge clk) disable iff (!rst_n) wake_evt |=> presc_ff == 16'h0000;
    endproperty
    a_wake_clears: assert property (p_wake_clears) else $error("wake did not clear");
    property p_always_on;
        @(posedge clk) disable iff (!rst_n) cfg.config_watchdog_always_on && lf_tick && !wdt_clear && !wdt_expire
            |=> presc_ff == $past(presc_ff) + 16'h0001;
    endproperty
    a_always_on: assert property (p_always_on) else $error("always-on did not count");
    property p_sw_off;
        @(posedge clk) disable iff (!rst_n) !run_en |=> presc_ff == 16'h0000 || presc_ff == $past(presc_ff);
    endproperty
    a_sw_off: assert property (p_sw_off) else $error("disabled watchdog counted");
    property p_irq_wake;
        @(posedge clk) disable iff (!rst_n) state_ff == wsc_pkg::WSC_ASLEEP && irq_pending && master_clear_pin_n
            |=> state_ff != wsc_pkg::WSC_ASLEEP;
    endproperty
    a_irq_wake: assert property (p_irq_wake) else $error("interrupt did not wake");
    property p_no_master_clear_pin;
        @(posedge clk) disable iff (!rst_n) evt.wdt_reset |-> !master_clear_drive_low;
    endproperty
    a_no_master_clear_pin: assert property (p_no_master_clear_pin) else $error("master clear driven");
endmodule

// ===== tb/wsc_core_model.sv
// processor core model: apb master that issues register accesses and the clear and sleep commands
// assumes one clock shared with the block; tasks are entered from the bench's own process
`include "wsc_regs.svh"
module wsc_core_model (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // bus idle at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end
    // one transfer; request held until pready is seen high at an edge, then released
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~wdata;  // released data must not look like the last value
    endtask
    // clear first so the sleep always starts from a zero count
    task automatic sleep_seq();
        logic [31:0] rd;
        logic er;
        xfer(1'b1, `WSC_OFF_CMD, 32'h00000001 << `WSC_CMD_CLEAR_WATCHDOG_INSTR, rd, er);
        xfer(1'b1, `WSC_OFF_CMD, 32'h00000001 << `WSC_CMD_SLEEP, rd, er);
    endtask
endmodule

// ===== tb/wsc_watchdog_sleep_tb_top.sv
// self-checking bench for the watchdog and sleep control block
// assumes the package, register header, design and core model are compiled before it
`include "wsc_regs.svh"
module wsc_watchdog_sleep_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TIMEOUT = 110000;
    logic clk;
    logic rst_n;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic er, ok, master_clear_pin_n, global_irq_enable;
    logic osc_driver_on, io_hold, master_clear_drive_low;
    logic [`WSC_IRQ_SRC_W-1:0] irq_flag, irq_enable;
    wsc_pkg::wsc_cfg_t cfg;
    wsc_pkg::wsc_evt_t evt;
    wsc_pkg::wsc_cfg_t cfg_tab [5] = '{3'h2, 3'h2, 3'h0, 3'h2, 3'h3};
    logic [3:0] evt_tab [5] = '{4'h5, 4'h4, 4'h2, 4'h0, 4'h4};
    logic [4:0] gie_tab = 5'h01;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    int t0;

    wsc_watchdog_sleep u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg(cfg),
        .master_clear_pin_n(master_clear_pin_n), .irq_flag(irq_flag), .irq_enable(irq_enable),
        .global_irq_enable(global_irq_enable), .evt(evt), .osc_driver_on(osc_driver_on), .io_hold(io_hold),
        .master_clear_drive_low(master_clear_drive_low));
    wsc_core_model u_core (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard: the expiry wait alone needs about 100k cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT) begin
            n_errors++;
            wrap_up();
        end
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk_val(input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic chk_evt(input wsc_pkg::wsc_evt_t exp, input wsc_pkg::wsc_evt_t got);
        chk_val(32'(exp), 32'(got));
    endtask
    task automatic reg_rd(input logic [11:0] addr, input logic [31:0] exp);
        u_core.xfer(1'b0, addr, 32'h00000000, rd, er);
        chk_val(exp, rd);
    endtask
    task automatic reg_wr(input logic [11:0] addr, input logic [31:0] data);
        u_core.xfer(1'b1, addr, data, rd, er);
    endtask
    // pulses stand one cycle, so every edge is looked at
    task automatic wait_evt(input int bound);
        for (int i = 0; i < bound; i++) begin
            @(posedge clk);
            if (evt !== 4'h0) break;
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        cfg = 3'h2;
        master_clear_pin_n = 1'b1;
        global_irq_enable = 1'b0;
        irq_flag = 6'h00;
        irq_enable = 6'h00;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        chk_val(32'h00000001, 32'(osc_driver_on));
        chk_val(32'h00000000, 32'(master_clear_drive_low));
        reg_rd(`WSC_OFF_WDT_CTRL, 32'h00000008);
        reg_rd(`WSC_OFF_PRESCALE_OPT, 32'h000000FF);
        reg_rd(`WSC_OFF_STATUS, 32'h00000003);
        $display("test reset values done");
        reg_wr(`WSC_OFF_WDT_CTRL, 32'hFFFFFFFF);
        reg_rd(`WSC_OFF_WDT_CTRL, 32'h0000001F);
        reg_wr(`WSC_OFF_WDT_CTRL, 32'h00000008);
        reg_wr(`WSC_OFF_PRESCALE_OPT, 32'h0000005A);
        reg_rd(`WSC_OFF_PRESCALE_OPT, 32'h0000005A);
        reg_wr(`WSC_OFF_STATUS, 32'h00000000);
        reg_rd(`WSC_OFF_STATUS, 32'h00000003);
        u_core.xfer(1'b0, 12'h014, 32'h00000000, rd, er);
        chk_val(32'h00000001, 32'(er));
        $display("test register access done");
        // enabled and flagged source before sleep: the command does nothing
        irq_flag <= 6'h03;
        irq_enable <= 6'h05;
        reg_rd(`WSC_OFF_IRQ_CTRL, 32'h00000001);
        reg_wr(`WSC_OFF_CMD, 32'h00000001 << `WSC_CMD_SLEEP);
        reg_rd(`WSC_OFF_STATUS, 32'h00000003);
        chk_val(32'h00000000, 32'(io_hold));
        irq_flag <= 6'h00;
        irq_enable <= 6'h00;
        $display("test sleep as no-operation done");
        // wake by irq with and without global enable, reset option, master clear, crystal start-up
        for (int i = 0; i < 5; i++) begin
            cfg <= cfg_tab[i];
            global_irq_enable <= gie_tab[i];
            u_core.sleep_seq();
            reg_rd(`WSC_OFF_STATUS, 32'h00000005);
            chk_val(32'h00000001, 32'(io_hold));
            chk_val(32'h00000000, 32'(osc_driver_on));
            if (i == 3) begin
                master_clear_pin_n <= 1'b0;
            end else begin
                irq_flag[i] <= 1'b1;
                repeat (4) @(posedge clk);
                chk_val(32'h00000001, 32'(io_hold));
                irq_enable[i] <= 1'b1;
            end
            if (i == 4) begin
                reg_rd(`WSC_OFF_STATUS, 32'h0000000D);
            end
            wait_evt(i == 4 ? 1100 : 8);
            chk_evt(evt_tab[i], evt);
            irq_flag <= 6'h00;
            irq_enable <= 6'h00;
            master_clear_pin_n <= 1'b1;
            chk_val(32'h00000000, 32'(io_hold));
            if (evt_tab[i][2]) begin
                reg_rd(`WSC_OFF_STATUS, 32'h00000001);
            end
        end
        $display("test wake-up causes done");
        reg_wr(`WSC_OFF_CMD, 32'h00000001 << `WSC_CMD_CLEAR_WATCHDOG_INSTR);
        reg_rd(`WSC_OFF_STATUS, 32'h00000003);
        // strap runs the watchdog though the software enable is off; shortest period 1:32
        cfg <= 3'h6;
        reg_wr(`WSC_OFF_WDT_CTRL, 32'h00000000);
        reg_wr(`WSC_OFF_CMD, 32'h00000001 << `WSC_CMD_CLEAR_WATCHDOG_INSTR);
        t0 = cycles;
        wait_evt(110000);
        chk_evt(4'h8, evt);
        ok = (cycles - t0 >= 29 * 3225) && (cycles - t0 <= 33 * 3225);
        chk_val(32'h00000001, 32'(ok));
        chk_val(32'h00000000, 32'(master_clear_drive_low));
        reg_rd(`WSC_OFF_STATUS, 32'h00000002);
        $display("test watchdog expiry done");
        wrap_up();
    end
endmodule
